// file: design/rate_enable_gen.sv
// Fractional divider making the 32 MHz and 16 MHz count enables from the system clock
`timescale 1ns/100ps
`include "timer_bank_map.svh"
module rate_enable_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      fast_en_o,
  output logic      slow_en_o
);
  localparam logic [5:0] SYS_STEP  = 6'(`SYS_CLK_MHZ);
  localparam logic [5:0] FAST_STEP = 6'(`FAST_CLK_MHZ);
  localparam logic [5:0] SLOW_STEP = 6'(`SLOW_CLK_MHZ);

  timer_bank_pkg::rate_state_t state_reg;
  timer_bank_pkg::rate_state_t state_next;
  logic [6:0]                  fast_sum;
  logic [6:0]                  slow_sum;

  // Average rate is exact; single pulses jitter by one system cycle
  always_comb begin
    state_next = state_reg;
    fast_sum   = {1'b0, state_reg.fast_acc} + {1'b0, FAST_STEP};
    slow_sum   = {1'b0, state_reg.slow_acc} + {1'b0, SLOW_STEP};
    state_next.fast_en = fast_sum >= {1'b0, SYS_STEP};
    state_next.slow_en = slow_sum >= {1'b0, SYS_STEP};
    state_next.fast_acc = state_next.fast_en ? 6'(fast_sum - {1'b0, SYS_STEP})
                                             : fast_sum[5:0];
    state_next.slow_acc = state_next.slow_en ? 6'(slow_sum - {1'b0, SYS_STEP})
                                             : slow_sum[5:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fast_en_o = state_reg.fast_en;
  assign slow_en_o = state_reg.slow_en;
endmodule : rate_enable_gen

// file: design/timer_bank.sv
// Nine-timer bank: clock selection, stop/disable, read-to-clear status, interrupts
//
// How it works
// R1: Each eligible timer picks 32 MHz or 16 MHz counting by software request.
// R2: The infrared pulse timer always counts at 16 MHz; fast select refused.
// R3: Request naming an unsupported timer fails and changes no selection.
// R4: Stop halts counting; block stays clocked and its registers reachable.
// R5: Disable stops the timer and gates its block clock.
// R6: Register access to a disabled timer answers with a bus error.
// R7: Software must re-enable a disabled timer before touching it again.
// R8: Reading a timer's status returns its flags and clears them.
// R9: Rising flag sets on a low-to-high output edge, its own bit.
// R10: End-of-period flag sets on a high-to-low output edge.
// R11: Taking a timer interrupt clears that timer's flags before the handler.
// R12: Software uses the clearing read only when polling, not in handlers.
// R13: Each timer has its own interrupt line toward the processor.
// R14: A timer interrupt is high while either flag is pending and unmasked.
`timescale 1ns/100ps
`include "timer_bank_map.svh"
module timer_bank (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  input  wire logic [`TIMER_COUNT-1:0] irq_take_i,
  output logic                         ack_o,
  output logic                         err_o,
  output logic [31:0]                  dat_o,
  output logic [`TIMER_COUNT-1:0]      timer_out_o,
  output logic [`TIMER_COUNT-1:0]      block_clk_en_o,
  output logic [`TIMER_COUNT-1:0]      timer_irq_o,
  output logic                         irq_o
);
  localparam int N = `TIMER_COUNT;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0]                    clk_sel;
    logic [N-1:0]                    run;
    logic [N-1:0]                    enabled;
    logic [`FLAG_W-1:0]              flags;
    logic [`FLAG_W-1:0]              mask;
    timer_bank_pkg::timer_cfg_t [N-1:0] cfg;
    logic                            req_done;
    logic                            req_fail;
    timer_bank_pkg::wb_rsp_t         rsp;
    logic [N-1:0]                    timer_out;
    logic [N-1:0]                    timer_irq;
    logic                            irq;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  // --------------------------------------------------------------------------
  // Bus request bundle
  // --------------------------------------------------------------------------
  timer_bank_pkg::wb_req_t req;
  assign req.cyc = cyc_i;
  assign req.stb = stb_i;
  assign req.we  = we_i;
  assign req.adr = adr_i;
  assign req.sel = sel_i;
  assign req.dat = dat_i;

  // --------------------------------------------------------------------------
  // Rate enables and timer slots
  // --------------------------------------------------------------------------
  logic                             fast_en;
  logic                             slow_en;
  logic [N-1:0]                     tick;
  logic [N-1:0]                     slot_out;
  timer_bank_pkg::timer_edge_t [N-1:0] slot_edge;
  logic [`FLAG_W-1:0]               edge_set;

  rate_enable_gen u_rate (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fast_en_o (fast_en),
    .slow_en_o (slow_en)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_slot
      // Stopped or gated timers see no tick and keep their count
      assign tick[g] = state_reg.run[g] && state_reg.enabled[g]
                       && (state_reg.clk_sel[g] ? fast_en : slow_en); // R1 R4 R5

      timer_slot u_slot (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (tick[g]),
        .hold_i (!state_reg.enabled[g]),
        .cfg_i  (state_reg.cfg[g]),
        .out_o  (slot_out[g]),
        .edge_o (slot_edge[g])
      );

      assign edge_set[2*g+`FIRED_RISE_BIT]   = slot_edge[g].rise; // R9
      assign edge_set[2*g+`FIRED_PERIOD_BIT] = slot_edge[g].fall; // R10
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic                   access;
  logic                   is_fired;
  logic                   is_cfg;
  logic [`TIMER_ID_W-1:0] slot_idx;
  logic                   slot_gated;
  logic                   mapped;

  assign access = req.cyc && req.stb && !state_reg.rsp.ack && !state_reg.rsp.err;
  assign is_fired = req.adr >= `OFF_FIRED_BASE && req.adr <= `OFF_FIRED_LAST
                    && req.adr[1:0] == 2'h0;
  assign is_cfg   = req.adr >= `OFF_CFG_BASE && req.adr <= `OFF_CFG_LAST
                    && req.adr[1:0] == 2'h0;

  always_comb begin
    slot_idx = '0;
    if (is_fired) begin
      slot_idx = `TIMER_ID_W'((req.adr - `OFF_FIRED_BASE) >> 2);
    end else if (is_cfg) begin
      slot_idx = `TIMER_ID_W'((req.adr - `OFF_CFG_BASE) >> 2);
    end
  end

  assign slot_gated = (is_fired || is_cfg) && !state_reg.enabled[slot_idx]; // R6 R7

  always_comb begin
    unique case (req.adr)
      `OFF_CLK_REQ, `OFF_CLK_SEL, `OFF_START, `OFF_STOP, `OFF_DISABLE,
      `OFF_ENABLE, `OFF_STATE, `OFF_MASK, `OFF_SUMMARY: mapped = 1'b1;
      default: mapped = is_fired || is_cfg;
    endcase
  end

  // --------------------------------------------------------------------------
  // Clock-select request check
  // --------------------------------------------------------------------------
  logic [`TIMER_ID_W-1:0] req_id;
  logic                   req_valid;

  assign req_id    = req.dat[`REQ_ID_LSB +: `TIMER_ID_W];
  assign req_valid = req_id < `TIMER_ID_W'(N) && req_id != `IR_TIMER_ID; // R2 R3

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic [`FLAG_W-1:0] flag_clr;
  logic [31:0]        wdat;
  logic [`FLAG_W-1:0] pend;

  always_comb begin
    state_next = state_reg;
    flag_clr   = '0;
    wdat       = req.dat;
    pend       = '0;

    state_next.rsp.ack = 1'b0;
    state_next.rsp.err = 1'b0;
    state_next.rsp.dat = 32'h0000_0000;

    // Interrupt taken by the processor drops that timer's flags
    for (int i = 0; i < N; i++) begin
      if (irq_take_i[i]) begin
        flag_clr[2*i +: 2] = 2'h3; // R11
      end
    end

    if (access) begin
      if (!mapped || slot_gated) begin
        state_next.rsp.err = 1'b1; // R6
      end else begin
        state_next.rsp.ack = 1'b1;
        if (req.we) begin
          unique case (req.adr)
            `OFF_CLK_REQ: begin
              state_next.req_done = 1'b1;
              state_next.req_fail = !req_valid; // R3
              if (req_valid) begin
                state_next.clk_sel[req_id] = wdat[`REQ_FAST_BIT]; // R1
              end
            end
            `OFF_START: begin
              state_next.run = state_reg.run | wdat[N-1:0];
            end
            `OFF_STOP: begin
              state_next.run = state_reg.run & ~wdat[N-1:0]; // R4
            end
            `OFF_DISABLE: begin
              state_next.run     = state_reg.run & ~wdat[N-1:0]; // R5
              state_next.enabled = state_reg.enabled & ~wdat[N-1:0]; // R5
            end
            `OFF_ENABLE: begin
              state_next.enabled = state_reg.enabled | wdat[N-1:0]; // R7
            end
            `OFF_MASK: begin
              state_next.mask = wdat[`FLAG_W-1:0];
            end
            default: begin
              if (is_cfg) begin
                if (req.sel[0]) state_next.cfg[slot_idx].high[7:0]    = wdat[7:0];
                if (req.sel[1]) state_next.cfg[slot_idx].high[15:8]   = wdat[15:8];
                if (req.sel[2]) state_next.cfg[slot_idx].period[7:0]  = wdat[23:16];
                if (req.sel[3]) state_next.cfg[slot_idx].period[15:8] = wdat[31:24];
              end
            end
          endcase
        end else begin
          unique case (req.adr)
            `OFF_CLK_REQ: begin
              state_next.rsp.dat[`REQ_DONE_BIT] = state_reg.req_done;
              state_next.rsp.dat[`REQ_FAIL_BIT] = state_reg.req_fail;
            end
            `OFF_CLK_SEL: state_next.rsp.dat[N-1:0] = state_reg.clk_sel;
            `OFF_START:   state_next.rsp.dat[N-1:0] = state_reg.run;
            `OFF_STATE:   state_next.rsp.dat[N-1:0] = state_reg.enabled;
            `OFF_MASK:    state_next.rsp.dat[`FLAG_W-1:0] = state_reg.mask;
            `OFF_SUMMARY: state_next.rsp.dat[`FLAG_W-1:0] = state_reg.flags;
            `OFF_STOP, `OFF_DISABLE, `OFF_ENABLE: state_next.rsp.dat = 32'h0000_0000;
            default: begin
              if (is_fired) begin
                // Returned flags include an edge landing this very cycle
                state_next.rsp.dat[1:0] = state_reg.flags[2*slot_idx +: 2]
                                          | edge_set[2*slot_idx +: 2]; // R8
                flag_clr[2*slot_idx +: 2] = 2'h3; // R8
              end else if (is_cfg) begin
                state_next.rsp.dat = state_reg.cfg[slot_idx];
              end
            end
          endcase
        end
      end
    end

    // Edges landing with a read were returned, so that clear wins; a take keeps them
    state_next.flags = (state_reg.flags & ~flag_clr)
                       | (edge_set & ~(flag_clr & ~irq_take_mask(irq_take_i))); // R9 R10

    // Per-timer and combined interrupt levels
    pend = state_next.flags & state_next.mask;
    for (int i = 0; i < N; i++) begin
      state_next.timer_irq[i] = |pend[2*i +: 2]; // R13 R14
    end
    state_next.irq       = |pend;
    state_next.timer_out = slot_out;
  end

  // An edge in the take cycle belongs to the next interrupt, not the one taken
  function automatic logic [`FLAG_W-1:0] irq_take_mask(input logic [N-1:0] take);
    logic [`FLAG_W-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      m[2*i +: 2] = {2{take[i]}};
    end
    return m;
  endfunction : irq_take_mask

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg         <= '0;
      state_reg.clk_sel <= `RST_CLK_SEL;
      state_reg.run     <= `RST_RUN;
      state_reg.enabled <= `RST_ENABLED;
      state_reg.mask    <= `RST_MASK;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign ack_o          = state_reg.rsp.ack;
  assign err_o          = state_reg.rsp.err;
  assign dat_o          = state_reg.rsp.dat;
  assign timer_out_o    = state_reg.timer_out;
  assign block_clk_en_o = state_reg.enabled; // R5
  assign timer_irq_o    = state_reg.timer_irq;
  assign irq_o          = state_reg.irq;
endmodule : timer_bank

// file: design/timer_bank_map.svh
// Register offsets, field positions, reset values and clock rates of the timer bank
`ifndef TIMER_BANK_MAP_SVH
`define TIMER_BANK_MAP_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define TIMER_COUNT        9
`define TIMER_ID_W         4
`define FLAG_W             18
`define IR_TIMER_ID        4'h5

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_CLK_REQ        8'h00
`define OFF_CLK_SEL        8'h04
`define OFF_START          8'h08
`define OFF_STOP           8'h0c
`define OFF_DISABLE        8'h10
`define OFF_ENABLE         8'h14
`define OFF_STATE          8'h18
`define OFF_MASK           8'h1c
`define OFF_SUMMARY        8'h20
`define OFF_FIRED_BASE     8'h40
`define OFF_FIRED_LAST     8'h60
`define OFF_CFG_BASE       8'h80
`define OFF_CFG_LAST       8'ha0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define REQ_ID_LSB         0
`define REQ_FAST_BIT       4
`define REQ_DONE_BIT       0
`define REQ_FAIL_BIT       1
`define FIRED_RISE_BIT     0
`define FIRED_PERIOD_BIT   1
`define CFG_HIGH_LSB       0
`define CFG_PERIOD_LSB     16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CLK_SEL        9'h000
`define RST_RUN            9'h000
`define RST_ENABLED        9'h1ff
`define RST_MASK           18'h3ffff
`define RST_CFG            32'h0000_0000

// ----------------------------------------------------------------------------
// Timing: system clock and the two counting rates, in MHz
// ----------------------------------------------------------------------------
`define SYS_CLK_MHZ        50
`define FAST_CLK_MHZ       32
`define SLOW_CLK_MHZ       16

`endif

// file: design/timer_bank_pkg.sv
// Types shared by the timer bank modules
package timer_bank_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] high;
  } timer_cfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } timer_edge_t;

  typedef struct packed {
    logic [15:0] count;
    logic        out;
    logic        rise;
    logic        fall;
  } slot_state_t;

  typedef struct packed {
    logic [5:0] fast_acc;
    logic [5:0] slow_acc;
    logic       fast_en;
    logic       slow_en;
  } rate_state_t;

endpackage : timer_bank_pkg

// file: design/timer_slot.sv
// One timer: counter, output waveform and its edge pulses
`timescale 1ns/100ps
module timer_slot (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        tick_i,
  input  wire logic                        hold_i,
  input  wire timer_bank_pkg::timer_cfg_t  cfg_i,
  output logic                             out_o,
  output timer_bank_pkg::timer_edge_t      edge_o
);
  timer_bank_pkg::slot_state_t state_reg;
  timer_bank_pkg::slot_state_t state_next;

  // Output is high while the count is below the high time
  always_comb begin
    state_next      = state_reg;
    state_next.rise = 1'b0;
    state_next.fall = 1'b0;
    if (!hold_i && tick_i) begin
      if (state_reg.count >= cfg_i.period) begin
        state_next.count = 16'h0000;
      end else begin
        state_next.count = state_reg.count + 16'h0001;
      end
      state_next.out  = state_next.count < cfg_i.high;
      state_next.rise = state_next.out && !state_reg.out;
      state_next.fall = !state_next.out && state_reg.out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign out_o       = state_reg.out;
  assign edge_o.rise = state_reg.rise;
  assign edge_o.fall = state_reg.fall;
endmodule : timer_slot

// file: tb/test_timer_bank.sv
// Self-checking bench for the timer bank
`timescale 1ns/100ps
`include "timer_bank_map.svh"
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, got, exp); \
  end \
end
module test_timer_bank;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [8:0]  irq_take_i;
  logic        ack_o;
  logic        err_o;
  logic [31:0] dat_o;
  logic [8:0]  timer_out_o;
  logic [8:0]  block_clk_en_o;
  logic [8:0]  timer_irq_o;
  logic        irq_o;
  int          miscompares;
  int          compares;
  int          r0;
  int          r1;
  int          exp_f;
  logic [8:0]  clk_sel_exp;
  logic [8:0]  run_exp;
  logic [8:0]  en_exp;
  logic [8:0]  prev;
  logic        fast;
  logic        ok;

  timer_bank i_timer_bank (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .irq_take_i(irq_take_i),
    .ack_o(ack_o), .err_o(err_o), .dat_o(dat_o), .timer_out_o(timer_out_o),
    .block_clk_en_o(block_clk_en_o), .timer_irq_o(timer_irq_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Far beyond the roughly three thousand cycles the sequence needs
  initial begin
    #1000000;
    miscompares++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // --------------------
  // Bus cycles
  // --------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 16) miscompares++;
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    wb(1'b0, a, 32'h0, q, e);
    `CHK(e, xe)
    `CHK(q, x)
  endtask : rd

  task automatic wait_out(input int i, input logic v);
    int n;
    n = 0;
    while (timer_out_o[i] !== v && n < 400) begin
      n++;
      @(posedge clk_i);
    end
    `CHK(timer_out_o[i], v)
  endtask : wait_out

  // Catch exactly one edge: clear, wait for it, stop before the next one
  task automatic one_edge(input int i, input logic rise, input logic [17:0] mask);
    logic [1:0]  flag;
    logic [31:0] q;
    logic        e;
    flag = rise ? 2'h1 : 2'h2;
    wr(`OFF_MASK, 32'(mask));
    wr(`OFF_CFG_BASE + 8'(4 * i), 32'h000f_0008);
    wr(`OFF_START, 32'h1 << i);
    // Let the opposite edge pass first, so the clear drops its flag and lands well before the wanted one
    wait_out(i, rise);
    wait_out(i, !rise);
    wb(1'b0, `OFF_FIRED_BASE + 8'(4 * i), 32'h0, q, e);
    wait_out(i, rise);
    wr(`OFF_STOP, 32'h1 << i);
    `CHK(timer_irq_o[i], |(mask[2 * i +: 2] & flag))
    wr(`OFF_MASK, 32'h3ffff);
    `CHK(timer_irq_o[i], 1'b1)
    `CHK(irq_o, 1'b1)
    rd(`OFF_SUMMARY, 32'(flag) << (2 * i), 1'b0);
    rd(`OFF_FIRED_BASE + 8'(4 * i), 32'(flag), 1'b0);
    rd(`OFF_FIRED_BASE + 8'(4 * i), 32'h0, 1'b0);
    `CHK(timer_irq_o[i], 1'b0)
    `CHK(irq_o, 1'b0)
  endtask : one_edge

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    irq_take_i = 9'h000;
    clk_sel_exp = `RST_CLK_SEL;
    run_exp = `RST_RUN;
    en_exp = `RST_ENABLED;
    void'($urandom(34383));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(block_clk_en_o, en_exp)
    rd(`OFF_CLK_SEL, 32'(clk_sel_exp), 1'b0);
    rd(`OFF_START, 32'(run_exp), 1'b0);
    rd(`OFF_STATE, 32'(en_exp), 1'b0);
    rd(`OFF_MASK, 32'(`RST_MASK), 1'b0);
    rd(8'hf0, 32'h0, 1'b1);
    for (int id = 0; id < 16; id++) begin
      fast = 1'($urandom);
      ok = id < 9 && id != 5;
      wr(`OFF_CLK_REQ, 32'({fast, 4'(id)}));
      if (ok) clk_sel_exp[id] = fast;
      rd(`OFF_CLK_REQ, {30'h0, !ok, 1'b1}, 1'b0);
      rd(`OFF_CLK_SEL, 32'(clk_sel_exp), 1'b0);
    end
    wr(`OFF_CLK_REQ, 32'h10);
    wr(`OFF_CLK_REQ, 32'h01);
    wr(`OFF_CFG_BASE, 32'h000f_0008);
    wr(`OFF_CFG_BASE + 8'h4, 32'h000f_0008);
    wr(`OFF_START, 32'h3);
    run_exp[1:0] = 2'b11;
    r0 = 0;
    r1 = 0;
    repeat (2000) begin
      prev = timer_out_o;
      @(posedge clk_i);
      r0 += int'(timer_out_o[0] & ~prev[0]);
      r1 += int'(timer_out_o[1] & ~prev[1]);
    end
    exp_f = 2000 * `FAST_CLK_MHZ / `SYS_CLK_MHZ / 16;
    `CHK(r0 > exp_f - 3 && r0 < exp_f + 3, 1'b1)
    exp_f = 2000 * `SLOW_CLK_MHZ / `SYS_CLK_MHZ / 16;
    `CHK(r1 > exp_f - 3 && r1 < exp_f + 3, 1'b1)
    wr(`OFF_STOP, 32'h3);
    run_exp[1:0] = 2'b00;
    rd(`OFF_START, 32'(run_exp), 1'b0);
    prev = timer_out_o;
    repeat (100) @(posedge clk_i);
    `CHK(timer_out_o, prev)
    rd(`OFF_CFG_BASE, 32'h000f_0008, 1'b0);
    rd(`OFF_FIRED_BASE, 32'h3, 1'b0);
    rd(`OFF_FIRED_BASE, 32'h0, 1'b0);
    `CHK(timer_irq_o[1:0], 2'b10)
    irq_take_i <= 9'h002;
    @(posedge clk_i);
    irq_take_i <= 9'h000;
    repeat (3) @(posedge clk_i);
    `CHK(timer_irq_o[1:0], 2'b00)
    rd(`OFF_FIRED_BASE + 8'h4, 32'h0, 1'b0);
    one_edge(2, 1'b1, 18'h3ffef);
    one_edge(3, 1'b0, 18'h3ff7f);
    wr(`OFF_START, 32'h10);
    wr(`OFF_DISABLE, 32'h11);
    en_exp = 9'h1ee;
    `CHK(block_clk_en_o, en_exp)
    rd(`OFF_START, 32'(run_exp), 1'b0);
    rd(`OFF_STATE, 32'(en_exp), 1'b0);
    rd(`OFF_FIRED_BASE + 8'h10, 32'h0, 1'b1);
    rd(`OFF_CFG_BASE, 32'h0, 1'b1);
    wr(`OFF_ENABLE, 32'h11);
    en_exp = 9'h1ff;
    `CHK(block_clk_en_o, en_exp)
    rd(`OFF_CFG_BASE, 32'h000f_0008, 1'b0);
    wrap_up();
  end
endmodule : test_timer_bank

// file: tb/timer_bank_checker.sv
// Port-level assertions for the timer bank
`timescale 1ns/100ps
`include "timer_bank_map.svh"
module timer_bank_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [8:0]  irq_take_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic [31:0] dat_o,
  input wire logic [8:0]  timer_out_o,
  input wire logic [8:0]  block_clk_en_o,
  input wire logic [8:0]  timer_irq_o,
  input wire logic        irq_o
);
  logic       take;
  logic       fired;
  logic       quiet;
  logic       wr_dis;
  logic       wr_ena;
  logic [8:0] dis_reg;
  logic [8:0] ena_reg;

  assign take   = cyc_i && stb_i && !ack_o && !err_o;
  assign fired  = adr_i >= `OFF_FIRED_BASE && adr_i <= `OFF_FIRED_LAST && adr_i[1:0] == 2'h0;
  assign quiet  = !take && !irq_take_i[0];
  assign wr_dis = take && we_i && adr_i == `OFF_DISABLE;
  assign wr_ena = take && we_i && adr_i == `OFF_ENABLE;

  // Masks held until the next write of the same kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_reg <= 9'h000;
      ena_reg <= 9'h000;
    end else if (wr_dis) begin
      dis_reg <= dat_i[8:0];
    end else if (wr_ena) begin
      ena_reg <= dat_i[8:0];
    end
  end

  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_answer_next: assert property (take |=> ack_o != err_o)
    else $error("request not answered in one cycle");
  a_answer_single: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
    else $error("answer held past one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_disable_gates: assert property (wr_dis |=> ##[0:1] !(block_clk_en_o & dis_reg))
    else $error("block clock not gated");
  a_enable_opens: assert property (wr_ena |=> ##[0:1] (block_clk_en_o & ena_reg) == ena_reg)
    else $error("block clock not restored");
  a_disabled_err: assert property (take && fired |=> err_o == !$past(block_clk_en_o[adr_i[5:2]]))
    else $error("status access answer wrong");
  a_unmapped_err: assert property (take && adr_i > `OFF_CFG_LAST |=> err_o)
    else $error("unmapped access not refused");
  a_edge_irq: assert property ($changed(timer_out_o[0]) && quiet && $past(quiet) |=> timer_irq_o[0])
    else $error("output edge raised no interrupt");
  for (genvar i = 0; i < 9; i++) begin : g_take
    a_take_clears: assert property (irq_take_i[i] ##1 !$changed(timer_out_o[i]) |-> !timer_irq_o[i])
      else $error("interrupt kept after take");
  end
endmodule : timer_bank_checker

bind timer_bank timer_bank_checker i_timer_bank_checker (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .irq_take_i(irq_take_i), .ack_o(ack_o), .err_o(err_o), .dat_o(dat_o),
  .timer_out_o(timer_out_o), .block_clk_en_o(block_clk_en_o),
  .timer_irq_o(timer_irq_o), .irq_o(irq_o));
